// ---- pme_defines.vh ----
// Offsets, field positions, reset values and counts for the PM1 event registers
`ifndef PME_DEFINES_VH
`define PME_DEFINES_VH

// ********************************************
// Register offsets from the block base
// ********************************************
`define PME_OFS_STATUS_WAKE 4'h1
`define PME_OFS_ENABLE_LOW 4'h2
`define PME_OFS_ENABLE_HIGH 4'h3
`define PME_OFS_CONTROL_LOW 4'h4

// ********************************************
// Field positions
// ********************************************
`define PME_BIT_WAKE_STATUS 7
`define PME_BIT_TIMER_CARRY_ENABLE 0
`define PME_BIT_GLOBAL_EVENT_ENABLE 5
`define PME_BIT_EVENT_ROUTE_SELECT 0
`define PME_BIT_BUSMASTER_RELOAD_ENABLE 1
`define PME_BIT_GLOBAL_RELEASE 2

// ********************************************
// Reset values
// ********************************************
`define PME_RST_STATUS_WAKE 8'h00
`define PME_RST_ENABLE_LOW 8'h00
`define PME_RST_ENABLE_HIGH 8'h00
`define PME_RST_CONTROL_LOW 8'h00

// ********************************************
// Writable masks and counts
// ********************************************
`define PME_MASK_ENABLE_LOW 8'h21
`define PME_MASK_CONTROL_LOW 8'h07
`define PME_SYNC_STAGES 3

`endif

// ---- pme_sync.v ----
// Three-stage pin synchroniser with agreement filter
module pme_sync #(
  parameter RESET_VALUE = 1'b0
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_pin,
  output reg o_level
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // ********************************************
  // Capture chain
  // ********************************************
  // Stage one feeds only stage two; filtering starts at stages two and three
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      s1_q <= RESET_VALUE;
      s2_q <= RESET_VALUE;
      s3_q <= RESET_VALUE;
      o_level <= RESET_VALUE;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end

endmodule

// ---- pme_regs.v ----
// PM1 event, enable and control registers with sleep/work sequencing
`include "pme_defines.vh"

module pme_regs #(
  parameter ADDR_W = 10
) (
  input wire I_CLK,
  input wire I_RSTN,
  input wire [ADDR_W-1:0] I_BASE,
  input wire [ADDR_W-1:0] I_ADDR,
  input wire I_IOR,
  input wire I_IOW,
  input wire [7:0] I_WDATA,
  input wire I_RESUME_EVENT,
  input wire I_RESUME_ENABLE,
  input wire I_STANDBY_EXPIRED,
  input wire I_ALL_DEV_SLEEPING,
  input wire I_TMR_MSB,
  input wire I_TIMER_STATUS_CLR,
  input wire I_GLOBAL_STATUS_CLR,
  input wire I_FIRMWARE_RELEASE_SET,
  input wire I_FIRMWARE_STATUS_CLR,
  input wire I_FIRMWARE_EVENT_ENABLE,
  input wire I_LEGACY_EVENT_ENABLE,
  input wire I_BUSMASTER_CONTROL_SET,
  input wire I_BUSMASTER_STATUS_CLR,
  output reg [7:0] O_RDATA,
  output reg O_RDATA_VLD,
  output reg O_SCI,
  output reg O_SMI,
  output reg O_WAKE_STATUS,
  output reg O_SLEEPING,
  output reg O_TIMER_CARRY_STATUS,
  output reg O_GLOBAL_EVENT_STATUS,
  output reg O_FIRMWARE_RELEASE,
  output reg O_FIRMWARE_EVENT_STATUS,
  output reg O_BUSMASTER_CONTROL,
  output reg O_BUSMASTER_STATUS
);

  // ********************************************
  // States of the sleep/work machine
  // ********************************************
  localparam [1:0] ST_WORKING = 2'b01;
  localparam [1:0] ST_SLEEPING = 2'b10;

  // ********************************************
  // Declarations
  // ********************************************
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg wake_status_q;
  reg wake_status_d;
  reg [7:0] enable_low_q;
  reg [7:0] control_low_q;
  reg timer_status_q;
  reg global_status_q;
  reg fw_release_q;
  reg fw_status_q;
  reg bm_control_q;
  reg bm_status_q;
  reg tmr_prev_q;
  reg tmr_seen_q;
  reg resume_prev_q;
  reg [7:0] rdata_d;
  reg rd_hit;
  wire resume_level;
  wire block_hit;
  wire [3:0] offset;
  wire wr_status_wake;
  wire wr_enable_low;
  wire wr_control_low;
  wire resume_edge;
  wire tmr_toggle;
  wire release_rise;
  wire pm_event;
  wire fw_event;
  wire route_sci;

  // ********************************************
  // Resume pin synchroniser
  // ********************************************
  pme_sync #(
    .RESET_VALUE(1'b0)
  ) u_resume_sync (
    .i_clk(I_CLK),
    .i_rstn(I_RSTN),
    .i_pin(I_RESUME_EVENT),
    .o_level(resume_level)
  );

  // ********************************************
  // Address decode
  // ********************************************
  // Base is 16-byte aligned, so only the upper bits are compared
  assign block_hit = (I_ADDR[ADDR_W-1:4] == I_BASE[ADDR_W-1:4]);
  assign offset = I_ADDR[3:0];
  assign wr_status_wake = I_IOW && block_hit && (offset == `PME_OFS_STATUS_WAKE);
  assign wr_enable_low = I_IOW && block_hit && (offset == `PME_OFS_ENABLE_LOW);
  assign wr_control_low = I_IOW && block_hit && (offset == `PME_OFS_CONTROL_LOW);

  // ********************************************
  // Event detection
  // ********************************************
  assign resume_edge = resume_level && !resume_prev_q;
  // First sample after reset only primes the history, so no false carry
  assign tmr_toggle = tmr_seen_q && (I_TMR_MSB != tmr_prev_q);
  assign release_rise = wr_control_low && I_WDATA[`PME_BIT_GLOBAL_RELEASE]
    && !control_low_q[`PME_BIT_GLOBAL_RELEASE];

  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      resume_prev_q <= 1'b0;
      tmr_prev_q <= 1'b0;
      tmr_seen_q <= 1'b0;
    end else begin
      resume_prev_q <= resume_level;
      tmr_prev_q <= I_TMR_MSB;
      tmr_seen_q <= 1'b1;
    end
  end

  // ********************************************
  // Wake status and sleep/work machine
  // ********************************************
  always @* begin
    wake_status_d = wake_status_q;
    state_d = state_q;
    if (wr_status_wake && I_WDATA[`PME_BIT_WAKE_STATUS]) begin
      wake_status_d = 1'b0;
    end
    if (I_STANDBY_EXPIRED) begin
      wake_status_d = 1'b0;
    end
    case (state_q)
      ST_WORKING: begin
        if (!wake_status_q && I_ALL_DEV_SLEEPING) begin
          state_d = ST_SLEEPING;
        end
      end
      ST_SLEEPING: begin
        // Set beats a clear arriving in the same cycle
        if (resume_edge && I_RESUME_ENABLE) begin
          wake_status_d = 1'b1;
          state_d = ST_WORKING;
        end
      end
      default: begin
        state_d = ST_WORKING;
      end
    endcase
  end

  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      state_q <= ST_WORKING;
      wake_status_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wake_status_q <= wake_status_d;
    end
  end

  // ********************************************
  // Enable and control registers
  // ********************************************
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      enable_low_q <= `PME_RST_ENABLE_LOW;
      control_low_q <= `PME_RST_CONTROL_LOW;
    end else begin
      if (wr_enable_low) begin
        enable_low_q <= I_WDATA & `PME_MASK_ENABLE_LOW;
      end
      if (wr_control_low) begin
        control_low_q <= I_WDATA & `PME_MASK_CONTROL_LOW;
      end
    end
  end

  // ********************************************
  // Event status bits
  // ********************************************
  // In every status bit a set arriving with its clear wins
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      timer_status_q <= 1'b0;
      global_status_q <= 1'b0;
      fw_release_q <= 1'b0;
      fw_status_q <= 1'b0;
      bm_control_q <= 1'b0;
      bm_status_q <= 1'b0;
    end else begin
      if (tmr_toggle) begin
        timer_status_q <= 1'b1;
      end else if (I_TIMER_STATUS_CLR) begin
        timer_status_q <= 1'b0;
      end
      if (I_FIRMWARE_RELEASE_SET) begin
        fw_release_q <= 1'b1;
        global_status_q <= 1'b1;
      end else if (I_GLOBAL_STATUS_CLR) begin
        fw_release_q <= 1'b0;
        global_status_q <= 1'b0;
      end
      if (release_rise) begin
        fw_status_q <= 1'b1;
      end else if (I_FIRMWARE_STATUS_CLR) begin
        fw_status_q <= 1'b0;
      end
      if (I_BUSMASTER_CONTROL_SET) begin
        bm_control_q <= 1'b1;
        bm_status_q <= 1'b1;
      end else if (I_BUSMASTER_STATUS_CLR) begin
        bm_control_q <= 1'b0;
        bm_status_q <= 1'b0;
      end
    end
  end

  // ********************************************
  // Interrupt routing
  // ********************************************
  // Level outputs: they follow status, so they drop once software clears it
  assign pm_event =
    (enable_low_q[`PME_BIT_TIMER_CARRY_ENABLE] && timer_status_q) ||
    (enable_low_q[`PME_BIT_GLOBAL_EVENT_ENABLE] && global_status_q) ||
    (control_low_q[`PME_BIT_BUSMASTER_RELOAD_ENABLE] && bm_control_q);
  assign fw_event = fw_status_q && I_FIRMWARE_EVENT_ENABLE;
  assign route_sci = control_low_q[`PME_BIT_EVENT_ROUTE_SELECT];

  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_SCI <= 1'b0;
      O_SMI <= 1'b0;
    end else begin
      O_SCI <= route_sci && pm_event;
      O_SMI <= (!route_sci && I_LEGACY_EVENT_ENABLE && pm_event) || fw_event;
    end
  end

  // ********************************************
  // Read path
  // ********************************************
  always @* begin
    rdata_d = 8'h00;
    rd_hit = 1'b0;
    if (I_IOR && block_hit) begin
      case (offset)
        `PME_OFS_STATUS_WAKE: begin
          rd_hit = 1'b1;
          rdata_d[`PME_BIT_WAKE_STATUS] = wake_status_q;
        end
        `PME_OFS_ENABLE_LOW: begin
          rd_hit = 1'b1;
          rdata_d = enable_low_q;
        end
        `PME_OFS_ENABLE_HIGH: begin
          rd_hit = 1'b1;
          rdata_d = `PME_RST_ENABLE_HIGH;
        end
        `PME_OFS_CONTROL_LOW: begin
          rd_hit = 1'b1;
          rdata_d = control_low_q;
        end
        default: begin
          rd_hit = 1'b0;
        end
      endcase
    end
  end

  // ********************************************
  // Registered outputs
  // ********************************************
  always @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_RDATA <= 8'h00;
      O_RDATA_VLD <= 1'b0;
      O_WAKE_STATUS <= 1'b0;
      O_SLEEPING <= 1'b0;
      O_TIMER_CARRY_STATUS <= 1'b0;
      O_GLOBAL_EVENT_STATUS <= 1'b0;
      O_FIRMWARE_RELEASE <= 1'b0;
      O_FIRMWARE_EVENT_STATUS <= 1'b0;
      O_BUSMASTER_CONTROL <= 1'b0;
      O_BUSMASTER_STATUS <= 1'b0;
    end else begin
      O_RDATA <= rdata_d;
      O_RDATA_VLD <= rd_hit;
      O_WAKE_STATUS <= wake_status_q;
      O_SLEEPING <= (state_q == ST_SLEEPING);
      O_TIMER_CARRY_STATUS <= timer_status_q;
      O_GLOBAL_EVENT_STATUS <= global_status_q;
      O_FIRMWARE_RELEASE <= fw_release_q;
      O_FIRMWARE_EVENT_STATUS <= fw_status_q;
      O_BUSMASTER_CONTROL <= bm_control_q;
      O_BUSMASTER_STATUS <= bm_status_q;
    end
  end

endmodule

// ---- pme_regs_props.sv ----
// Checker bound to the PM1 event register block
module pme_regs_props #(
  parameter ADDR_W = 10
) (
  input wire I_CLK,
  input wire I_RSTN,
  input wire [ADDR_W-1:0] I_BASE,
  input wire [ADDR_W-1:0] I_ADDR,
  input wire I_IOR,
  input wire I_RESUME_ENABLE,
  input wire I_STANDBY_EXPIRED,
  input wire I_ALL_DEV_SLEEPING,
  input wire I_TMR_MSB,
  input wire I_FIRMWARE_RELEASE_SET,
  input wire [7:0] O_RDATA,
  input wire O_SCI,
  input wire O_WAKE_STATUS,
  input wire O_SLEEPING,
  input wire O_TIMER_CARRY_STATUS,
  input wire O_GLOBAL_EVENT_STATUS,
  input wire O_FIRMWARE_RELEASE,
  input wire O_BUSMASTER_CONTROL
);
  // ******************
  // Decode and steps
  // ******************
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  wire [3:0] ofs = I_ADDR[3:0];
  wire hit = I_ADDR[ADDR_W-1:4] == I_BASE[ADDR_W-1:4];
  wire rd_ok = I_IOR && hit && ofs >= 4'h1 && ofs <= 4'h4;
  wire [7:0] keep = ofs == 4'h1 ? 8'h80 : ofs == 4'h2 ? 8'h21 : ofs == 4'h4 ? 8'h07 : 8'h00;
  // Carry history is primed at the first edge after reset
  sequence carry_seen;
    $past(I_RSTN, 2) && $past(I_RSTN) && $changed(I_TMR_MSB);
  endsequence
  sequence all_idle;
    I_ALL_DEV_SLEEPING && !I_RESUME_ENABLE ##1 !O_WAKE_STATUS;
  endsequence
  rsvd_zero_a: assert property (rd_ok |=> (O_RDATA & ~$past(keep)) == 8'h00)
    else $error("reserved bit read as one");
  carry_set_a: assert property (carry_seen |-> ##2 O_TIMER_CARRY_STATUS)
    else $error("carry status not set");
  wake_sleep_a: assert property ($rose(O_WAKE_STATUS) |-> $past(O_SLEEPING))
    else $error("wake set while working");
  wake_work_a: assert property ($rose(O_WAKE_STATUS) |-> !O_SLEEPING)
    else $error("no return to working");
  standby_clr_a: assert property (
    I_STANDBY_EXPIRED && !I_RESUME_ENABLE |-> ##2 !O_WAKE_STATUS)
    else $error("wake kept after standby");
  sleep_entry_a: assert property (all_idle |=> ##[0:1] O_SLEEPING)
    else $error("sleep not entered");
  global_set_a: assert property (
    I_FIRMWARE_RELEASE_SET |-> ##2 O_GLOBAL_EVENT_STATUS && O_FIRMWARE_RELEASE)
    else $error("global status not set");
  sci_cause_a: assert property (
    O_SCI |-> O_TIMER_CARRY_STATUS || O_GLOBAL_EVENT_STATUS || O_BUSMASTER_CONTROL)
    else $error("sci without status");
endmodule

bind pme_regs pme_regs_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ---- pme_regs_bench.sv ----
// Self-checking bench for the PM1 event register block
module pme_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic I_CLK = 1'b0, I_RSTN = 1'b0, I_IOR = 1'b0, I_IOW = 1'b0, I_TMR_MSB = 1'b0;
  logic I_RESUME_EVENT = 1'b0, I_RESUME_ENABLE = 1'b0, I_ALL_DEV_SLEEPING = 1'b0;
  logic I_FIRMWARE_EVENT_ENABLE = 1'b0, I_LEGACY_EVENT_ENABLE = 1'b0;
  logic [9:0] I_BASE = 10'h120, I_ADDR = 10'h000;
  logic [7:0] I_WDATA = 8'h00, O_RDATA, d;
  logic [6:0] pl = 7'h00;
  // Strobes share one vector so one task can pulse any of them
  wire I_TIMER_STATUS_CLR = pl[0], I_GLOBAL_STATUS_CLR = pl[1];
  wire I_FIRMWARE_RELEASE_SET = pl[2], I_FIRMWARE_STATUS_CLR = pl[3];
  wire I_BUSMASTER_CONTROL_SET = pl[4], I_BUSMASTER_STATUS_CLR = pl[5];
  wire I_STANDBY_EXPIRED = pl[6];
  logic O_RDATA_VLD, O_SCI, O_SMI, O_WAKE_STATUS, O_SLEEPING, O_TIMER_CARRY_STATUS;
  logic O_GLOBAL_EVENT_STATUS, O_FIRMWARE_RELEASE, O_FIRMWARE_EVENT_STATUS;
  logic O_BUSMASTER_CONTROL, O_BUSMASTER_STATUS;
  logic [7:0] exp_q[$];
  int failures = 0;
  int cmp_count = 0;
  pme_regs dut (.*);
  initial forever #2.5 I_CLK = ~I_CLK;
  // ******************
  // Tasks
  // ******************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge I_CLK);
  endtask
  task automatic acc(input logic wr, input logic [3:0] ofs, input logic [7:0] v);
    cyc(1);
    I_ADDR = I_BASE + {6'h00, ofs};
    I_WDATA = v;
    {I_IOW, I_IOR} = {wr, !wr};
    cyc(1);
    {I_IOW, I_IOR} = 2'b00;
  endtask
  // Offsets outside 1..4 must give no answer, so nothing is noted
  task automatic rd(input logic [3:0] ofs, input logic [7:0] e);
    if (ofs >= 4'h1 && ofs <= 4'h4) exp_q.push_back(e);
    acc(1'b0, ofs, 8'h00);
  endtask
  task automatic pulse(input int k);
    pl = 7'(1 << k);
    cyc(1);
    pl = 7'h00;
    cyc(2);
  endtask
  task automatic wake;
    int n;
    I_RESUME_EVENT = 1'b1;
    for (n = 0; n < 20 && O_WAKE_STATUS !== 1'b1; n++) cyc(1);
    I_RESUME_EVENT = 1'b0;
    chk1("wake status", 1'b1, O_WAKE_STATUS);
    if (n == 20) close_out();
  endtask
  task automatic close_out;
    chk("reads left", 8'h00, 8'(exp_q.size()));
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge I_CLK) begin
    if (O_RDATA_VLD === 1'b1) begin
      if (exp_q.size() == 0) chk("read valid", 8'h00, 8'h01);
      else chk("read data", exp_q.pop_front(), O_RDATA);
    end
  end
  initial begin
    void'($urandom(68569));
    cyc(8);
    I_RSTN = 1'b1;
    for (int i = 0; i < 6; i++) rd(4'(i), 8'h00);
    $display("reset test done");
    repeat (4) begin
      d = 8'($urandom());
      for (int i = 1; i < 5; i++) acc(1'b1, 4'(i), d);
      rd(4'h1, 8'h00);
      rd(4'h2, d & 8'h21);
      rd(4'h3, 8'h00);
      rd(4'h4, d & 8'h07);
    end
    $display("register test done");
    pulse(3);
    acc(1'b1, 4'h2, 8'h01);
    acc(1'b1, 4'h4, 8'h01);
    I_TMR_MSB = 1'b1;
    cyc(3);
    chk1("carry status", 1'b1, O_TIMER_CARRY_STATUS);
    chk1("sci on carry", 1'b1, O_SCI);
    pulse(0);
    chk1("sci cleared", 1'b0, O_SCI);
    chk1("carry cleared", 1'b0, O_TIMER_CARRY_STATUS);
    acc(1'b1, 4'h4, 8'h00);
    I_TMR_MSB = 1'b0;
    cyc(3);
    chk1("smi legacy off", 1'b0, O_SMI);
    chk1("sci routed off", 1'b0, O_SCI);
    I_LEGACY_EVENT_ENABLE = 1'b1;
    cyc(2);
    chk1("smi on carry", 1'b1, O_SMI);
    pulse(0);
    acc(1'b1, 4'h2, 8'h00);
    acc(1'b1, 4'h4, 8'h01);
    I_TMR_MSB = 1'b1;
    cyc(3);
    chk1("sci carry masked", 1'b0, O_SCI);
    pulse(0);
    $display("timer test done");
    acc(1'b1, 4'h2, 8'h20);
    pulse(2);
    chk1("sci on global", 1'b1, O_SCI);
    chk1("global status", 1'b1, O_GLOBAL_EVENT_STATUS);
    chk1("release set", 1'b1, O_FIRMWARE_RELEASE);
    pulse(1);
    chk1("release cleared", 1'b0, O_FIRMWARE_RELEASE);
    chk1("global cleared", 1'b0, O_GLOBAL_EVENT_STATUS);
    chk1("sci global off", 1'b0, O_SCI);
    acc(1'b1, 4'h2, 8'h00);
    pulse(4);
    chk1("bm status", 1'b1, O_BUSMASTER_STATUS);
    chk1("bm control set", 1'b1, O_BUSMASTER_CONTROL);
    chk1("sci reload off", 1'b0, O_SCI);
    acc(1'b1, 4'h4, 8'h03);
    cyc(2);
    chk1("sci on reload", 1'b1, O_SCI);
    pulse(5);
    chk1("bm control", 1'b0, O_BUSMASTER_CONTROL);
    chk1("bm status clear", 1'b0, O_BUSMASTER_STATUS);
    chk1("sci bm cleared", 1'b0, O_SCI);
    acc(1'b1, 4'h4, 8'h00);
    acc(1'b1, 4'h4, 8'h04);
    cyc(3);
    chk1("firmware status", 1'b1, O_FIRMWARE_EVENT_STATUS);
    chk1("smi fw masked", 1'b0, O_SMI);
    I_FIRMWARE_EVENT_ENABLE = 1'b1;
    cyc(2);
    chk1("smi on release", 1'b1, O_SMI);
    pulse(3);
    chk1("smi cleared", 1'b0, O_SMI);
    chk1("firmware cleared", 1'b0, O_FIRMWARE_EVENT_STATUS);
    $display("event test done");
    I_ALL_DEV_SLEEPING = 1'b1;
    cyc(3);
    chk1("sleeping", 1'b1, O_SLEEPING);
    I_RESUME_ENABLE = 1'b1;
    wake();
    chk1("working", 1'b0, O_SLEEPING);
    acc(1'b1, 4'h1, 8'h7F);
    rd(4'h1, 8'h80);
    acc(1'b1, 4'h1, 8'h80);
    rd(4'h1, 8'h00);
    cyc(3);
    chk1("asleep again", 1'b1, O_SLEEPING);
    wake();
    // Resume disabled so the standby clear is seen without a competing set
    I_RESUME_ENABLE = 1'b0;
    pulse(6);
    chk1("standby clear", 1'b0, O_WAKE_STATUS);
    $display("sleep test done");
    close_out();
  end
endmodule
